// ---- inc/lram_pkg.sv ----
// Constants and types shared by the large dual-port RAM block.
package lram_pkg;
    localparam int LRAM_LANE_W = 9;
    localparam int LRAM_BYTE_W = 8;
    localparam int LRAM_LANES = 16;
    localparam int LRAM_LANE_IW = 4;
    localparam int LRAM_ROW_W = 144;
    localparam int LRAM_ROWS = 4096;
    localparam int LRAM_TOTAL_BITS = 589824;
    localparam int LRAM_ROW_AW = 12;
    localparam int LRAM_ADDR_W = 16;
    localparam int LRAM_PORT_W = 72;
    localparam int LRAM_MASK_W = 8;
    localparam logic [2:0] LRAM_X9 = 3'h0;
    localparam logic [2:0] LRAM_X18 = 3'h1;
    localparam logic [2:0] LRAM_X36 = 3'h2;
    localparam logic [2:0] LRAM_X72 = 3'h3;
    localparam logic [2:0] LRAM_X144 = 3'h4;
    localparam logic LRAM_CLK_A = 1'b0;
    localparam logic LRAM_CLK_B = 1'b1;
    localparam logic [31:0] LRAM_CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] LRAM_STATUS_OFS = 32'h0000_0004;
    localparam int LRAM_STAT_REJECT = 0;
    localparam logic [2:0] LRAM_HSIZE_WORD = 3'h2;
    localparam int LRAM_HTRANS_ACT = 1;

    typedef enum logic [1:0] {LRAM_TRUE_DP, LRAM_SIMPLE_DP, LRAM_SINGLE, LRAM_FIFO} lram_mode_type;

    typedef struct packed {
        logic out_clk_b;
        logic in_clk_b;
        logic out_clk_a;
        logic in_clk_a;
        logic outreg_b;
        logic outreg_a;
        logic lane8;
        logic [2:0] width_b;
        logic [2:0] width_a;
        lram_mode_type mode;
    } lram_cfg_type;

    localparam int LRAM_CFG_W = $bits(lram_cfg_type);

    localparam lram_cfg_type LRAM_CFG_RESET = '{out_clk_b: LRAM_CLK_B, in_clk_b: LRAM_CLK_B,
        out_clk_a: LRAM_CLK_A, in_clk_a: LRAM_CLK_A, outreg_b: 1'b1, outreg_a: 1'b1, lane8: 1'b0,
        width_b: LRAM_X72, width_a: LRAM_X72, mode: LRAM_TRUE_DP};

    typedef struct packed {
        logic we;
        logic read_select;
        logic [LRAM_ADDR_W-1:0] addr;
        logic [LRAM_PORT_W-1:0] wdata;
        logic [LRAM_MASK_W-1:0] mask;
    } lram_port_type;

    typedef struct packed {
        logic fresh;
        logic we;
        logic read_select;
        logic [LRAM_ADDR_W-1:0] addr;
        logic [2*LRAM_PORT_W-1:0] wdata;
        logic [2*LRAM_MASK_W-1:0] mask;
    } lram_capt_type;
endpackage

// ---- rtl/lram_port_in.sv ----
// Input register stage of one RAM port.
`timescale 1ns/1ps
`default_nettype none
module lram_port_in
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Port clock pulses and controls.
    input wire logic tick_a,
    input wire logic tick_b,
    input wire logic in_clk_sel,
    input wire logic clken,
    input wire logic clr,
    // Captured fields.
    input wire lram_pkg::lram_capt_type d,
    output var lram_pkg::lram_capt_type q
);
    import lram_pkg::*;

    logic cap;

    // ==========================================================
    // Capture on the selected port clock pulse.
    assign cap = ((in_clk_sel == LRAM_CLK_B) ? tick_b : tick_a) && clken;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
        end
        else if (clr)
        begin
            q <= '0;
        end
        else if (cap)
        begin
            q <= d;
            q.fresh <= 1'b1;
        end
        else
        begin
            q.fresh <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/lram_block.sv ----
// Large dual-port RAM block with an AHB-Lite configuration slave.
`timescale 1ns/1ps
`default_nettype none
module lram_block
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite register slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Port clock pulses.
    input wire logic tick_a,
    input wire logic tick_b,
    // Port A.
    input wire logic clken_a,
    input wire logic clr_a,
    input wire lram_pkg::lram_port_type port_a,
    output logic [lram_pkg::LRAM_PORT_W-1:0] rdata_a,
    // Port B.
    input wire logic clken_b,
    input wire logic clr_b,
    input wire lram_pkg::lram_port_type port_b,
    output logic [lram_pkg::LRAM_PORT_W-1:0] rdata_b
);
    import lram_pkg::*;

    logic [LRAM_ROW_W-1:0] mem [LRAM_ROWS];
    lram_cfg_type cfg;
    lram_cfg_type new_cfg;
    logic reject;
    logic take;
    logic ap_valid;
    logic ap_write;
    logic [31:0] ap_addr;
    logic wr_ctrl;
    logic wr_status;
    logic new_ok;
    logic [31:0] rd_value;
    lram_capt_type d_a;
    lram_capt_type d_b;
    lram_capt_type ca;
    lram_capt_type cb;
    logic w144;
    logic l8;
    logic sdp;
    logic [LRAM_LANE_IW-1:0] base_a;
    logic [LRAM_LANE_IW-1:0] base_b;
    logic [LRAM_LANE_IW:0] lanes_a;
    logic [LRAM_LANE_IW:0] lanes_b;
    logic [LRAM_ROW_AW-1:0] row_a;
    logic [LRAM_ROW_AW-1:0] row_b;
    logic a_wr;
    logic a_rd;
    logic b_wr;
    logic b_rd;
    logic [LRAM_LANES-1:0] wen_a;
    logic [LRAM_LANES-1:0] wen_b;
    logic [LRAM_LANE_W-1:0] wd_a [LRAM_LANES];
    logic [LRAM_LANE_W-1:0] wd_b [LRAM_LANES];
    logic [LRAM_PORT_W-1:0] arr_q_a;
    logic [LRAM_PORT_W-1:0] arr_q_b;
    logic [LRAM_PORT_W-1:0] next_arr_a;
    logic [LRAM_PORT_W-1:0] next_arr_b;
    logic ld_a;
    logic ld_b;
    logic byp_a;
    logic byp_b;
    logic ev_a;
    logic ev_b;

    // ==========================================================
    // Helper functions.

    // Moves 8-bit user lanes into the 9-bit storage lanes.
    function automatic logic [LRAM_PORT_W-1:0] spread(input logic [LRAM_PORT_W-1:0] d, input logic b8);
        logic [LRAM_PORT_W-1:0] r;
        r = d;
        if (b8)
        begin
            for (int k = 0; k < LRAM_MASK_W; k++)
            begin
                r[k*LRAM_LANE_W +: LRAM_LANE_W] = {1'b0, d[k*LRAM_BYTE_W +: LRAM_BYTE_W]};
            end
        end
        return r;
    endfunction

    // Takes the port's lanes out of a stored row.
    function automatic logic [LRAM_PORT_W-1:0] pick(input logic [LRAM_ROW_W-1:0] word,
        input logic [LRAM_LANE_IW-1:0] base, input logic [2:0] w, input logic b8);
        logic [LRAM_ROW_W-1:0] s;
        logic [LRAM_PORT_W-1:0] r;
        s = word >> (LRAM_LANE_W * base);
        r = '0;
        for (int k = 0; k < LRAM_MASK_W; k++)
        begin
            if (k < (1 << w))
            begin
                if (b8)
                begin
                    r[k*LRAM_BYTE_W +: LRAM_BYTE_W] = s[k*LRAM_LANE_W +: LRAM_BYTE_W];
                end
                else
                begin
                    r[k*LRAM_LANE_W +: LRAM_LANE_W] = s[k*LRAM_LANE_W +: LRAM_LANE_W];
                end
            end
        end
        return r;
    endfunction

    // Checks a shape and mode combination.
    function automatic logic legal(input lram_cfg_type c);
        logic ok;
        logic wide;
        ok = (c.width_a <= LRAM_X144) && (c.width_b <= LRAM_X144);
        wide = (c.width_a == LRAM_X144) || (c.width_b == LRAM_X144);
        if (wide)
        begin
            ok = ok && (c.width_a == c.width_b) && ((c.mode == LRAM_SIMPLE_DP) || (c.mode == LRAM_FIFO));
        end
        return ok;
    endfunction

    // ==========================================================
    // AHB-Lite slave.

    assign take = hready && hsel && htrans[LRAM_HTRANS_ACT] && (hsize == LRAM_HSIZE_WORD);
    assign wr_ctrl = ap_valid && ap_write && hready && (ap_addr == LRAM_CTRL_OFS);
    assign wr_status = ap_valid && ap_write && hready && (ap_addr == LRAM_STATUS_OFS);
    assign new_cfg = lram_cfg_type'(hwdata[LRAM_CFG_W-1:0]);
    assign new_ok = legal(new_cfg);

    always_comb
    begin
        rd_value = '0;
        if (ap_addr == LRAM_CTRL_OFS)
        begin
            rd_value[LRAM_CFG_W-1:0] = cfg;
        end
        else if (ap_addr == LRAM_STATUS_OFS)
        begin
            rd_value[LRAM_STAT_REJECT] = reject;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= '0;
        end
        else if (hready)
        begin
            ap_valid <= take;
            ap_write <= hwrite;
            ap_addr <= haddr;
        end
    end

    // Reads insert one wait state so that a preceding write is visible.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= '0;
        end
        else
        begin
            hresp <= 1'b0;
            hreadyout <= !(take && !hwrite);
            if (ap_valid && !ap_write && !hreadyout)
            begin
                hrdata <= rd_value;
            end
        end
    end

    // Configuration; an illegal combination is refused and flagged.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg <= LRAM_CFG_RESET;
        end
        else if (wr_ctrl && new_ok)
        begin
            cfg <= new_cfg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            reject <= 1'b0;
        end
        else
        begin
            reject <= (wr_ctrl && !new_ok) || (reject && !(wr_status && hwdata[LRAM_STAT_REJECT]));
        end
    end

    // ==========================================================
    // Input register stages.

    assign w144 = (cfg.width_a == LRAM_X144);
    assign l8 = cfg.lane8;
    assign sdp = (cfg.mode == LRAM_SIMPLE_DP) || (cfg.mode == LRAM_FIFO);

    always_comb
    begin
        d_a = '0;
        d_a.we = port_a.we;
        d_a.read_select = port_a.read_select;
        d_a.addr = port_a.addr;
        d_a.wdata[LRAM_PORT_W-1:0] = spread(port_a.wdata, l8);
        d_a.mask[LRAM_MASK_W-1:0] = port_a.mask;
        if (w144)
        begin
            d_a.wdata[2*LRAM_PORT_W-1:LRAM_PORT_W] = spread(port_b.wdata, l8);
            d_a.mask[2*LRAM_MASK_W-1:LRAM_MASK_W] = port_b.mask;
        end
        d_b = '0;
        d_b.we = port_b.we;
        d_b.read_select = port_b.read_select;
        d_b.addr = port_b.addr;
        d_b.wdata[LRAM_PORT_W-1:0] = spread(port_b.wdata, l8);
        d_b.mask[LRAM_MASK_W-1:0] = port_b.mask;
    end

    lram_port_in u_in_a
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick_a(tick_a),
        .tick_b(tick_b),
        .in_clk_sel(cfg.in_clk_a),
        .clken(clken_a),
        .clr(clr_a),
        .d(d_a),
        .q(ca)
    );

    lram_port_in u_in_b
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick_a(tick_a),
        .tick_b(tick_b),
        .in_clk_sel(cfg.in_clk_b),
        .clken(clken_b),
        .clr(clr_b),
        .d(d_b),
        .q(cb)
    );

    // ==========================================================
    // Address split and operation decode.

    always_comb
    begin
        row_a = LRAM_ROW_AW'(ca.addr >> (LRAM_X144 - cfg.width_a));
        row_b = LRAM_ROW_AW'(cb.addr >> (LRAM_X144 - cfg.width_b));
        base_a = LRAM_LANE_IW'(ca.addr << cfg.width_a);
        base_b = LRAM_LANE_IW'(cb.addr << cfg.width_b);
        lanes_a = (LRAM_LANE_IW+1)'(1) << cfg.width_a;
        lanes_b = (LRAM_LANE_IW+1)'(1) << cfg.width_b;
        a_wr = ca.fresh && ca.we;
        a_rd = ca.fresh && !ca.we && ((cfg.mode == LRAM_TRUE_DP) || (cfg.mode == LRAM_SINGLE));
        b_wr = cb.fresh && cb.we && (cfg.mode == LRAM_TRUE_DP);
        b_rd = cb.fresh && ((cfg.mode == LRAM_TRUE_DP) ? !cb.we : (sdp && cb.read_select));
    end

    // ==========================================================
    // Per-lane write enables and data.

    for (genvar j = 0; j < LRAM_LANES; j++)
    begin : g_lane
        logic [LRAM_LANE_IW-1:0] rel_a;
        logic [LRAM_LANE_IW-1:0] rel_b;
        assign rel_a = LRAM_LANE_IW'(j) - base_a;
        assign rel_b = LRAM_LANE_IW'(j) - base_b;
        assign wen_a[j] = a_wr && ({1'b0, rel_a} < lanes_a) && (ca.mask[rel_a] || (cfg.width_a == LRAM_X9));
        assign wen_b[j] = b_wr && ({1'b0, rel_b} < lanes_b) && (cb.mask[rel_b] || (cfg.width_b == LRAM_X9));
        assign wd_a[j] = ca.wdata[rel_a*LRAM_LANE_W +: LRAM_LANE_W];
        assign wd_b[j] = cb.wdata[rel_b*LRAM_LANE_W +: LRAM_LANE_W];
    end

    // ==========================================================
    // Storage array: no reset and no preload.

    always_ff @(posedge hclk)
    begin
        for (int j = 0; j < LRAM_LANES; j++)
        begin
            if (wen_b[j])
            begin
                mem[row_b][j*LRAM_LANE_W +: LRAM_LANE_W] <= wd_b[j];
            end
            if (wen_a[j])
            begin
                mem[row_a][j*LRAM_LANE_W +: LRAM_LANE_W] <= wd_a[j];
            end
        end
    end

    // ==========================================================
    // Read path and output registers.

    always_comb
    begin
        if (w144)
        begin
            next_arr_a = pick(mem[row_b], '0, LRAM_X72, l8);
            next_arr_b = pick(mem[row_b], LRAM_LANE_IW'(LRAM_MASK_W), LRAM_X72, l8);
            ld_a = b_rd;
            byp_a = !cfg.outreg_b;
            ev_a = ((cfg.out_clk_b == LRAM_CLK_B) ? tick_b : tick_a) && clken_b;
        end
        else
        begin
            next_arr_a = pick(mem[row_a], base_a, cfg.width_a, l8);
            next_arr_b = pick(mem[row_b], base_b, cfg.width_b, l8);
            ld_a = a_rd;
            byp_a = !cfg.outreg_a;
            ev_a = ((cfg.out_clk_a == LRAM_CLK_B) ? tick_b : tick_a) && clken_a;
        end
        ld_b = b_rd;
        byp_b = !cfg.outreg_b;
        ev_b = ((cfg.out_clk_b == LRAM_CLK_B) ? tick_b : tick_a) && clken_b;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            arr_q_a <= '0;
            rdata_a <= '0;
        end
        else if (clr_a)
        begin
            arr_q_a <= '0;
            rdata_a <= '0;
        end
        else
        begin
            if (ld_a)
            begin
                arr_q_a <= next_arr_a;
            end
            if (ld_a && byp_a)
            begin
                rdata_a <= next_arr_a;
            end
            else if (!byp_a && ev_a)
            begin
                rdata_a <= arr_q_a;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            arr_q_b <= '0;
            rdata_b <= '0;
        end
        else if (clr_b)
        begin
            arr_q_b <= '0;
            rdata_b <= '0;
        end
        else
        begin
            if (ld_b)
            begin
                arr_q_b <= next_arr_b;
            end
            if (ld_b && byp_b)
            begin
                rdata_b <= next_arr_b;
            end
            else if (!byp_b && ev_b)
            begin
                rdata_b <= arr_q_b;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/lram_block_assertions.sv ----
// Concurrent checks on the ports of the large dual-port RAM block.
`timescale 1ns/1ps
`default_nettype none
module lram_block_assertions
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bus slave.
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Ports.
    input wire logic clken_a,
    input wire logic clr_a,
    input wire logic [lram_pkg::LRAM_PORT_W-1:0] rdata_a,
    input wire logic clken_b,
    input wire logic clr_b,
    input wire logic [lram_pkg::LRAM_PORT_W-1:0] rdata_b
);
    import lram_pkg::*;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // =========================================
    // Sequences.
    sequence rd_taken;
        hsel && hready && htrans[1] && !hwrite && hsize == LRAM_HSIZE_WORD;
    endsequence
    sequence wr_taken;
        hsel && hready && htrans[1] && hwrite && hsize == LRAM_HSIZE_WORD;
    endsequence
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence ports_idle;
        (!clken_a && !clken_b && !clr_a && !clr_b) [*3];
    endsequence
    // =========================================
    // Assertions.
    resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
    write_no_wait_a: assert property (wr_taken |=> hreadyout) else $error("wait state on write");
    read_wait_a: assert property (rd_taken |=> one_wait) else $error("read wait not one cycle");
    wait_cause_a: assert property (!hreadyout |-> $past(hsel && hready && htrans[1] && !hwrite
        && hsize == LRAM_HSIZE_WORD)) else $error("wait state without read");
    hrdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
    clear_port_a_a: assert property (clr_a |=> rdata_a == '0) else $error("rdata_a not cleared");
    clear_port_b_a: assert property (clr_b |=> rdata_b == '0) else $error("rdata_b not cleared");
    idle_hold_a: assert property (ports_idle |=> $stable(rdata_a) && $stable(rdata_b))
        else $error("read data moved while idle");
endmodule
bind lram_block lram_block_assertions i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .clken_a(clken_a), .clr_a(clr_a), .rdata_a(rdata_a), .clken_b(clken_b), .clr_b(clr_b), .rdata_b(rdata_b));
`default_nettype wire

// ---- verification/lram_user_model.sv ----
// Model of fabric user logic driving one RAM port.
`timescale 1ns/1ps
`default_nettype none
module lram_user_model
(
    // Clock.
    input wire logic hclk,
    // Port request.
    output logic tick,
    output logic clken,
    output var lram_pkg::lram_port_type port
);
    import lram_pkg::*;
    initial
    begin
        tick = 1'b0;
        clken = 1'b0;
        port = '{we: 1'b0, read_select: 1'b0, addr: '0, wdata: '0, mask: 8'hff};
    end
    // One port clock with a request; afterwards data and address show garbage.
    task automatic access(input logic ce, input logic we, input logic [15:0] a, input logic [71:0] d,
        input logic [7:0] m);
        tick <= 1'b1;
        clken <= ce;
        port <= '{we: we, read_select: !we, addr: a, wdata: d, mask: m};
        @(posedge hclk);
        tick <= 1'b0;
        clken <= 1'b0;
        port.we <= 1'b0;
        port.addr <= ~a;
        port.wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ---- verification/lram_block_test.sv ----
// Self-checking testbench of the large dual-port RAM block.
`timescale 1ns/1ps
`default_nettype none
module lram_block_test;
    import lram_pkg::*;
    typedef struct {logic b; logic ce; logic we; logic [15:0] a; logic [71:0] d; logic [7:0] m;} lram_row_type;
    localparam logic [71:0] d1 = 72'h123456789abcdef012;
    localparam logic [71:0] d2 = 72'hedcba9876543210fed;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, clr_a, clr_b, tick_a, tick_b, clken_a, clken_b;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready;
    lram_port_type port_a, port_b;
    logic [71:0] rdata_a, rdata_b;
    logic [71:0] mem [int];
    int fails, checks_done;
    lram_row_type rows [10] = '{'{0, 1, 1, 10, d1, 8'hff}, '{1, 1, 1, 10, d2, 8'h81}, '{0, 1, 0, 10, d1, 8'hff},
        '{1, 1, 1, 11, d1, 8'hff}, '{0, 1, 1, 11, d2, 8'h00}, '{1, 1, 0, 11, d1, 8'hff},
        '{0, 1, 1, 11, d2, 8'h3c}, '{1, 1, 0, 11, d1, 8'hff}, '{0, 0, 1, 10, d1, 8'hff}, '{1, 1, 0, 10, d1, 8'hff}};
    lram_row_type rows8 [3] = '{'{0, 1, 1, 13, d1, 8'hff}, '{0, 1, 1, 13, d2, 8'h02}, '{1, 1, 0, 13, d1, 8'hff}};
    logic [31:0] bad_cfg [3] = '{32'h0000_0090, 32'h0000_0074, 32'h0000_0071};
    assign hready = hreadyout;
    lram_block i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .tick_a(tick_a), .tick_b(tick_b), .clken_a(clken_a), .clr_a(clr_a), .port_a(port_a),
        .rdata_a(rdata_a), .clken_b(clken_b), .clr_b(clr_b), .port_b(port_b), .rdata_b(rdata_b));
    lram_user_model u_a (.hclk(hclk), .tick(tick_a), .clken(clken_a), .port(port_a));
    lram_user_model u_b (.hclk(hclk), .tick(tick_b), .clken(clken_b), .port(port_b));
    // =========================================
    // Tasks.
    task automatic check(input logic [71:0] seen, input logic [71:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("Checks %0d, mismatches %0d.", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= LRAM_HSIZE_WORD;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    function automatic logic [71:0] merge(input logic [71:0] old, input logic [71:0] nw, input logic [7:0] m,
        input int lw);
        for (int k = 0; k < 8; k++)
            for (int j = 0; j < lw; j++)
                if (m[k])
                    old[k * lw + j] = nw[k * lw + j];
        return old;
    endfunction
    task automatic do_row(input lram_row_type r, input int lw);
        logic [71:0] keep;
        keep = {{8{lw == 9}}, {64{1'b1}}};
        @(posedge hclk);
        if (r.b)
            u_b.access(r.ce, r.we, r.a, r.d, r.m);
        else
            u_a.access(r.ce, r.we, r.a, r.d, r.m);
        if (r.we && r.ce)
            mem[r.a] = merge(mem[r.a], r.d, r.m, lw);
        @(posedge hclk);
        #1;
        if (!r.we)
            check((r.b ? rdata_b : rdata_a) & keep, mem[r.a] & keep);
    endtask
    // =========================================
    // Clock, watchdog and main sequence.
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial
    begin
        repeat (20000) @(posedge hclk);
        fails++;
        summarize();
    end
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = '0;
        clr_a = 1'b0;
        clr_b = 1'b0;
        fails = 0;
        checks_done = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, LRAM_CTRL_OFS, '0);
        check(72'(rd), 72'h666c);
        ahb(1'b0, LRAM_STATUS_OFS, '0);
        check(72'(rd), 72'h0);
        check(rdata_a, '0);
        check(rdata_b, '0);
        ahb(1'b1, LRAM_CTRL_OFS, 32'h0000_606c);
        ahb(1'b0, LRAM_CTRL_OFS, '0);
        check(72'(rd), 72'h606c);
        foreach (rows[i])
            do_row(rows[i], 9);
        @(posedge hclk);
        foreach (bad_cfg[i])
        begin
            ahb(1'b1, LRAM_CTRL_OFS, bad_cfg[i]);
            ahb(1'b0, LRAM_STATUS_OFS, '0);
            check(72'(rd), 72'h1);
            ahb(1'b0, LRAM_CTRL_OFS, '0);
            check(72'(rd), 72'h606c);
            ahb(1'b1, LRAM_STATUS_OFS, 32'h1);
            ahb(1'b0, LRAM_STATUS_OFS, '0);
            check(72'(rd), 72'h0);
        end
        ahb(1'b1, 32'h0000_0010, 32'hffff_ffff);
        ahb(1'b0, 32'h0000_0010, '0);
        check(72'(rd), 72'h0);
        @(posedge hclk);
        ahb(1'b1, LRAM_CTRL_OFS, 32'h0000_616c);
        foreach (rows8[i])
            do_row(rows8[i], 8);
        // Simple dual-port: port A writes, port B reads with its read select.
        @(posedge hclk);
        ahb(1'b1, LRAM_CTRL_OFS, 32'h0000_606d);
        do_row(lram_row_type'{1'b0, 1'b1, 1'b1, 16'd12, d2, 8'hff}, 9);
        do_row(lram_row_type'{1'b1, 1'b1, 1'b0, 16'd12, d1, 8'hff}, 9);
        @(posedge hclk);
        clr_a <= 1'b1;
        clr_b <= 1'b1;
        @(posedge hclk);
        clr_a <= 1'b0;
        clr_b <= 1'b0;
        @(posedge hclk);
        #1;
        check(rdata_a, '0);
        check(rdata_b, '0);
        // Registered read: data reaches the output only on a later port clock.
        @(posedge hclk);
        ahb(1'b1, LRAM_CTRL_OFS, 32'h0000_666c);
        @(posedge hclk);
        u_a.access(1'b1, 1'b0, 16'd10, '0, 8'hff);
        @(posedge hclk);
        #1;
        check(rdata_a, '0);
        @(posedge hclk);
        u_a.access(1'b1, 1'b0, 16'd10, '0, 8'hff);
        #1;
        check(rdata_a, mem[10]);
        summarize();
    end
endmodule
`default_nettype wire
